// [rtcx_core.sv]
// rtc flag, extension, scratch and clock counter registers on ahb-lite
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "rtcx_regs.svh"

module rtcx_core #(
  parameter int unsigned P_SEC_CYC = `RTCX_CLK_HZ,
  parameter int unsigned P_REL_SEC_CYC =
    `RTCX_CLK_HZ / 1000 * `RTCX_REL_SEC_MS,
  parameter int unsigned P_REL_MIN_CYC =
    `RTCX_CLK_HZ / 1000000 * `RTCX_REL_MIN_US,
  parameter int unsigned P_HALF_MID_CYC =
    `RTCX_CLK_HZ / (2 * `RTCX_FREQ_OUTPUT_PIN_MID_HZ),
  parameter int unsigned P_HALF_LO_CYC =
    `RTCX_CLK_HZ / (2 * `RTCX_FREQ_OUTPUT_PIN_LO_HZ),
  parameter int unsigned P_TICK_FAST_CYC =
    `RTCX_CLK_HZ / `RTCX_TSRC_FAST_HZ,
  parameter int unsigned P_TICK_SLOW_CYC =
    `RTCX_CLK_HZ / `RTCX_TSRC_SLOW_HZ
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire rtcx_pkg::rtcx_ahb_req_t i_ahb,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_temp_comp_halt,
  output logic o_freq_output_pin,
  output logic o_update_irq,
  output logic o_timer_tick,
  output logic o_alarm_target_select
);
  // fast half period is fixed by the clock macro, not a parameter
  localparam int unsigned HALF_HI_CYC =
    `RTCX_CLK_HZ / (2 * `RTCX_FREQ_OUTPUT_PIN_HI_HZ);

  // bcd increment with wrap at top
  function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                          input logic [7:0] top);
    logic [7:0] r;
    r = 8'h00;
    if (v == top) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay

  logic ap_wr_q;
  logic [5:0] ap_idx_q;
  logic [31:0] rdata_q;
  wire logic ap_take;
  wire logic [5:0] ap_idx;

  assign ap_take = i_ahb.hsel && i_ahb.htrans[1] && i_hready;
  assign ap_idx = i_ahb.haddr[7:2];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;

  // data phase write strobes
  wire logic wr_sec;
  wire logic wr_min;
  wire logic wr_hour;
  wire logic wr_ram;
  wire logic wr_ext;
  wire logic wr_flag;
  assign wr_sec = ap_wr_q && (ap_idx_q == `RTCX_IDX_SEC);
  assign wr_min = ap_wr_q && (ap_idx_q == `RTCX_IDX_MIN);
  assign wr_hour = ap_wr_q && (ap_idx_q == `RTCX_IDX_HOUR);
  assign wr_ram = ap_wr_q && (ap_idx_q == `RTCX_IDX_RAM);
  assign wr_ext = ap_wr_q && (ap_idx_q == `RTCX_IDX_EXT);
  assign wr_flag = ap_wr_q && (ap_idx_q == `RTCX_IDX_FLAG);

  // address phase capture
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ap_wr_q <= 1'b0;
      ap_idx_q <= 6'h00;
    end else begin
      ap_wr_q <= ap_take && i_ahb.hwrite;
      ap_idx_q <= ap_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase and registers

  logic [31:0] pre_q;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [7:0] ram_q;
  logic flag_q;
  logic halt_m_q;
  logic halt_s_q;
  rtcx_pkg::rtcx_ext_t ext_q;

  wire logic sec_tick;
  wire logic min_tick;
  wire logic hour_tick;
  assign sec_tick = (pre_q == P_SEC_CYC - 1);
  assign min_tick = sec_tick && (sec_q == `RTCX_SEC_TOP);
  assign hour_tick = min_tick && (min_q == `RTCX_MIN_TOP);

  // next values; a write beats a tick so software can set the time
  wire logic [7:0] sec_d;
  wire logic [7:0] min_d;
  wire logic [7:0] hour_d;
  wire logic [7:0] ram_d;
  wire logic flag_d;
  wire rtcx_pkg::rtcx_ext_t ext_d;
  assign sec_d = wr_sec ? (i_hwdata[7:0] & `RTCX_SEC_MASK) :
    sec_tick ? bcd_next(sec_q, `RTCX_SEC_TOP) : sec_q;
  assign min_d = wr_min ? (i_hwdata[7:0] & `RTCX_MIN_MASK) :
    min_tick ? bcd_next(min_q, `RTCX_MIN_TOP) : min_q;
  assign hour_d = wr_hour ? (i_hwdata[7:0] & `RTCX_HOUR_MASK) :
    hour_tick ? bcd_next(hour_q, `RTCX_HOUR_TOP) : hour_q;
  assign ram_d = wr_ram ? i_hwdata[7:0] : ram_q;
  assign ext_d = wr_ext ? rtcx_pkg::rtcx_ext_t'(i_hwdata[7:0]) : ext_q;
  // halt beats the clear so no event is lost; a 1 write is ignored
  assign flag_d = halt_s_q ? 1'b1 :
    (wr_flag && !i_hwdata[`RTCX_FLAG_STOP_BIT]) ? 1'b0 : flag_q;

  // halt input comes from the analog side, so synchronise it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      halt_m_q <= 1'b0;
      halt_s_q <= 1'b0;
    end else begin
      halt_m_q <= i_temp_comp_halt;
      halt_s_q <= halt_m_q;
    end
  end

  // register state; reset stands for power-up from zero volts
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= 32'h0000_0000;
      sec_q <= `RTCX_CNT_RST;
      min_q <= `RTCX_CNT_RST;
      hour_q <= `RTCX_CNT_RST;
      ram_q <= `RTCX_RAM_RST;
      ext_q <= rtcx_pkg::rtcx_ext_t'(`RTCX_EXT_RST);
      flag_q <= `RTCX_FLAG_RST;
    end else begin
      pre_q <= sec_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      sec_q <= sec_d;
      min_q <= min_d;
      hour_q <= hour_d;
      ram_q <= ram_d;
      ext_q <= ext_d;
      flag_q <= flag_d;
    end
  end

  // read mux looks at next values so a read right after a write sees it
  wire logic [31:0] rd_mux;
  assign rd_mux =
    (ap_idx == `RTCX_IDX_SEC) ? {24'h00_0000, sec_d} :
    (ap_idx == `RTCX_IDX_MIN) ? {24'h00_0000, min_d} :
    (ap_idx == `RTCX_IDX_HOUR) ? {24'h00_0000, hour_d} :
    (ap_idx == `RTCX_IDX_RAM) ? {24'h00_0000, ram_d} :
    (ap_idx == `RTCX_IDX_EXT) ? {24'h00_0000, ext_d} :
    (ap_idx == `RTCX_IDX_FLAG) ? {31'h0000_0000, flag_d} :
    32'h0000_0000; // unmapped reads zero

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (ap_take && !i_ahb.hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // update interrupt with automatic release

  logic [31:0] rel_q;
  logic upd_irq_q;
  wire logic upd_evt;
  wire logic [31:0] rel_len;
  assign upd_evt = ext_q.update_period_select ? min_tick : sec_tick;
  assign rel_len = ext_q.update_period_select ? P_REL_MIN_CYC :
    P_REL_SEC_CYC;
  assign o_update_irq = upd_irq_q;

  // release counts down from the selected hold time
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rel_q <= 32'h0000_0000;
      upd_irq_q <= 1'b0;
    end else if (upd_evt) begin
      rel_q <= rel_len - 32'h0000_0001;
      upd_irq_q <= 1'b1;
    end else if (rel_q != 32'h0000_0000) begin
      rel_q <= rel_q - 32'h0000_0001;
    end else begin
      upd_irq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic timer source tick

  logic [31:0] fast_q;
  logic [31:0] slow_q;
  logic tick_q;
  wire logic fast_tick;
  wire logic slow_tick;
  wire logic src_tick;
  assign fast_tick = (fast_q == P_TICK_FAST_CYC - 1);
  assign slow_tick = (slow_q == P_TICK_SLOW_CYC - 1);
  assign src_tick =
    (ext_q.timer_src_sel == rtcx_pkg::RTCX_TSRC_FAST) ? fast_tick :
    (ext_q.timer_src_sel == rtcx_pkg::RTCX_TSRC_SLOW) ? slow_tick :
    (ext_q.timer_src_sel == rtcx_pkg::RTCX_TSRC_SEC) ? sec_tick :
    min_tick;
  assign o_timer_tick = tick_q;
  assign o_alarm_target_select = ext_q.alarm_target_select;

  // ticks reach o_timer_tick only while the timer runs
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fast_q <= 32'h0000_0000;
      slow_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      fast_q <= fast_tick ? 32'h0000_0000 : fast_q + 32'h0000_0001;
      slow_q <= slow_tick ? 32'h0000_0000 : slow_q + 32'h0000_0001;
      tick_q <= ext_q.timer_run && src_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frequency output; the 32768 Hz rate is approximate at this clock

  logic [31:0] fcnt_q;
  logic freq_output_pin_q;
  wire logic [31:0] half_cyc;
  wire logic freq_output_pin_flip;
  assign half_cyc =
    (ext_q.out_rate_sel == rtcx_pkg::RTCX_RATE_MID) ? P_HALF_MID_CYC :
    (ext_q.out_rate_sel == rtcx_pkg::RTCX_RATE_LO) ? P_HALF_LO_CYC :
    HALF_HI_CYC;
  // >= so a switch to a faster rate never waits a long period out
  assign freq_output_pin_flip = (fcnt_q >= half_cyc - 1);
  assign o_freq_output_pin = freq_output_pin_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fcnt_q <= 32'h0000_0000;
      freq_output_pin_q <= 1'b0;
    end else if (freq_output_pin_flip) begin
      fcnt_q <= 32'h0000_0000;
      freq_output_pin_q <= !freq_output_pin_q;
    end else begin
      fcnt_q <= fcnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  logic first_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  chk_flag_powerup: assert property (first_q |-> flag_q)
    else $error("stop flag not set after power-up");
  chk_flag_set: assert property (halt_s_q |=> flag_q)
    else $error("stop flag missed a halt");
  chk_flag_hold: assert property (
    flag_q && !(wr_flag && !i_hwdata[0]) |=> flag_q)
    else $error("stop flag dropped without a zero write");
  chk_flag_clear: assert property (
    wr_flag && !i_hwdata[0] && !halt_s_q |=> !flag_q)
    else $error("stop flag not cleared by zero write");
  chk_sec_wrap: assert property (
    sec_tick && sec_q == 8'h59 && !wr_sec |=> sec_q == 8'h00)
    else $error("seconds did not wrap");
  chk_min_carry: assert property (
    sec_tick && sec_q == 8'h59 && min_q == 8'h59 && !wr_sec && !wr_min
    |=> min_q == 8'h00 && sec_q == 8'h00)
    else $error("minutes did not wrap on carry");
  chk_hour_wrap: assert property (
    hour_tick && hour_q == 8'h23 && !wr_hour && !wr_min
    |=> hour_q == 8'h00)
    else $error("hours did not wrap");
  chk_sec_advance: assert property (
    sec_tick && sec_q == 8'h08 && !wr_sec |=> sec_q == 8'h09)
    else $error("seconds did not advance");
  chk_unused_zero: assert property (
    !sec_q[7] && !min_q[7] && hour_q[7:6] == 2'b00)
    else $error("unused counter bit set");
  chk_ram_store: assert property (
    wr_ram |=> ram_q == $past(i_hwdata[7:0]))
    else $error("scratch byte lost a write");
  chk_release_hold: assert property (
    $rose(upd_irq_q) |-> upd_irq_q [*8])
    else $error("update release too early");
  chk_tick_gated: assert property (tick_q |-> $past(ext_q.timer_run))
    else $error("timer tick while stopped");
  chk_tsrc_sec: assert property (
    ext_q.timer_run && ext_q.timer_src_sel == 2'b10 && sec_tick
    |=> tick_q)
    else $error("second source tick missing");

  cov_sec_wrap: cover property (sec_tick && sec_q == 8'h59);
  cov_flag_clear: cover property (flag_q ##1 !flag_q);
  cov_update_irq: cover property ($rose(upd_irq_q));
  cov_timer_tick: cover property (tick_q);

endmodule
`default_nettype wire

// [rtcx_regs.svh]
// register indices, field positions, reset values and timing figures
`ifndef RTCX_REGS_SVH
`define RTCX_REGS_SVH
// word indices; byte address is four times the index
`define RTCX_IDX_SEC 6'h00
`define RTCX_IDX_MIN 6'h01
`define RTCX_IDX_HOUR 6'h02
`define RTCX_IDX_RAM 6'h07
`define RTCX_IDX_EXT 6'h0d
`define RTCX_IDX_FLAG 6'h0f
// field positions
`define RTCX_FLAG_STOP_BIT 0
`define RTCX_EXT_TEST_BIT 7
`define RTCX_EXT_ALARM_BIT 6
`define RTCX_EXT_UPD_BIT 5
`define RTCX_EXT_RUN_BIT 4
// writable masks of the clock counters
`define RTCX_SEC_MASK 8'h7f
`define RTCX_MIN_MASK 8'h7f
`define RTCX_HOUR_MASK 8'h3f
// bcd wrap points
`define RTCX_SEC_TOP 8'h59
`define RTCX_MIN_TOP 8'h59
`define RTCX_HOUR_TOP 8'h23
// reset values
`define RTCX_FLAG_RST 1'b1
`define RTCX_EXT_RST 8'h00
`define RTCX_CNT_RST 8'h00
`define RTCX_RAM_RST 8'h00
// timing figures in their own units
`define RTCX_CLK_HZ 25000000
`define RTCX_REL_SEC_MS 500
`define RTCX_REL_MIN_US 7813
`define RTCX_FREQ_OUTPUT_PIN_HI_HZ 32768
`define RTCX_FREQ_OUTPUT_PIN_MID_HZ 1024
`define RTCX_FREQ_OUTPUT_PIN_LO_HZ 1
`define RTCX_TSRC_FAST_HZ 4096
`define RTCX_TSRC_SLOW_HZ 64
`endif

// [rtcx_pkg.sv]
// types shared by the rtc register block
package rtcx_pkg;
  // ahb-lite address phase signals
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [7:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } rtcx_ahb_req_t;

  // extension control byte, msb first
  typedef struct packed {
    logic test;
    logic alarm_target_select;
    logic update_period_select;
    logic timer_run;
    logic [1:0] out_rate_sel;
    logic [1:0] timer_src_sel;
  } rtcx_ext_t;

  typedef enum logic [1:0] {
    RTCX_RATE_HI = 2'b00,
    RTCX_RATE_MID = 2'b01,
    RTCX_RATE_LO = 2'b10,
    RTCX_RATE_HI2 = 2'b11
  } rtcx_rate_t;

  typedef enum logic [1:0] {
    RTCX_TSRC_FAST = 2'b00,
    RTCX_TSRC_SLOW = 2'b01,
    RTCX_TSRC_SEC = 2'b10,
    RTCX_TSRC_MIN = 2'b11
  } rtcx_tsrc_t;
endpackage

// [testbench.sv]
// self-checking bench for the rtc register block
`timescale 1ns/1ns
`default_nettype none
`include "rtcx_regs.svh"
module testbench;
  // shortened counts handed to the design
  localparam int SC = 50;
  localparam int RS = 20;
  localparam int RM = 10;
  localparam int HM = 8;
  localparam int HL = 16;
  localparam int TF = 12;
  localparam int TS = 24;
  localparam rtcx_pkg::rtcx_ahb_req_t IDLE =
    '{1'b0, 2'b00, 8'h00, 1'b0, 3'b010};
  logic i_mclk;
  logic i_rst_n;
  rtcx_pkg::rtcx_ahb_req_t ahb;
  logic [31:0] hwdata;
  logic halt;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic resp;
  wire logic [2:0] mon;  // tick, freq, irq
  wire logic asel;
  int err_count;
  int checks_done;
  int n;
  int m;
  int e;
  logic [31:0] rng;
  logic [31:0] rd;
  logic [23:0] t;
  logic [7:0] v;
  logic [23:0] corner [3] = '{24'h05_0959, 24'h09_5959, 24'h23_5959};
  logic [5:0] ids [6] = '{`RTCX_IDX_SEC, `RTCX_IDX_MIN, `RTCX_IDX_HOUR,
                          `RTCX_IDX_RAM, `RTCX_IDX_EXT, 6'h03};

  rtcx_core #(.P_SEC_CYC(SC), .P_REL_SEC_CYC(RS), .P_REL_MIN_CYC(RM),
    .P_HALF_MID_CYC(HM), .P_HALF_LO_CYC(HL), .P_TICK_FAST_CYC(TF),
    .P_TICK_SLOW_CYC(TS)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_ahb(ahb), .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(resp), .i_temp_comp_halt(halt),
    .o_freq_output_pin(mon[1]), .o_update_irq(mon[0]),
    .o_timer_tick(mon[2]), .o_alarm_target_select(asel));

  // free-running 25 mhz clock
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [7:0] inc(input logic [7:0] a,
                                     input logic [7:0] top);
    if (a == top) return 8'h00;
    return (a[3:0] == 4'h9) ? {a[7:4] + 4'h1, 4'h0} : a + 8'h01;
  endfunction
  // one second later, carries only when the lower digit pair wraps
  function automatic logic [23:0] nxt(input logic [23:0] a);
    logic [23:0] r;
    r = {a[23:8], inc(a[7:0], 8'h59)};
    if (a[7:0] == 8'h59) r[15:8] = inc(a[15:8], 8'h59);
    if (a[15:0] == 16'h5959) r[23:16] = inc(a[23:16], 8'h23);
    return r;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
    wrap_up();
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge i_mclk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 16) hang();
      @(posedge i_mclk);
    end
  endtask
  // one single word transfer; called just after a rising edge
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [7:0] d, output logic [31:0] r);
    ahb <= '{1'b1, 2'b10, {idx, 2'b00}, w, 3'b010};
    wait_rdy();
    ahb <= IDLE;
    hwdata <= {24'h00_0000, d};
    wait_rdy();
    // a non-okay response spoils the read data so the compare trips
    r = (resp === 1'b0) ? hrdata : ~hrdata;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rc(input logic [5:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, rd);
    chk(rd, {24'h00_0000, e});
  endtask
  // cycles until mon[b] next changes
  task automatic gap(input int b, output int c);
    logic o;
    o = mon[b];
    c = 0;
    do begin
      @(posedge i_mclk);
      c++;
      if (c > 4000) hang();
    end while (mon[b] === o);
  endtask
  // polls seconds until they move, so a whole second lies ahead
  task automatic sync_sec;
    logic [31:0] r0;
    int j;
    bus(1'b0, `RTCX_IDX_SEC, 8'h00, r0);
    j = 0;
    do begin
      bus(1'b0, `RTCX_IDX_SEC, 8'h00, rd);
      j++;
      if (j > 40) hang();
    end while (rd === r0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    checks_done = 0;
    rng = 32'h0000_0050;
    i_rst_n = 1'b0;
    halt = 1'b0;
    hwdata = 32'h0000_0000;
    ahb = IDLE;
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rc(`RTCX_IDX_FLAG, 8'h01);
    foreach (ids[i]) rc(ids[i], 8'h00);
    wr(6'h03, 8'ha5);
    rc(6'h03, 8'h00);
    wr(`RTCX_IDX_FLAG, 8'h01);
    rc(`RTCX_IDX_FLAG, 8'h01);
    wr(`RTCX_IDX_FLAG, 8'hfe);
    rc(`RTCX_IDX_FLAG, 8'h00);
    wr(`RTCX_IDX_FLAG, 8'h01);
    rc(`RTCX_IDX_FLAG, 8'h00);
    halt <= 1'b1;
    repeat (4) @(posedge i_mclk);
    halt <= 1'b0;
    repeat (4) @(posedge i_mclk);
    rc(`RTCX_IDX_FLAG, 8'h01);
    rc(`RTCX_IDX_FLAG, 8'h01);
    for (int i = 0; i < 18; i++) begin
      rng = xs(rng);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rng[7:0];
      wr(`RTCX_IDX_RAM, v);
      rc(`RTCX_IDX_RAM, v);
    end
    // test bit kept low by software
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      v = rng[7:0] & 8'h7f;
      wr(`RTCX_IDX_EXT, v);
      rc(`RTCX_IDX_EXT, v);
      chk({31'h0, asel}, {31'h0, v[6]});
    end
    for (int c = 0; c < 4; c++) begin
      wr(`RTCX_IDX_EXT, {4'h0, c[1:0], 2'b00});
      repeat (3) gap(1, n);
      chk(n, (c == 1) ? HM : (c == 2) ? HL : 381);
    end
    for (int c = 0; c < 4; c++) begin
      wr(`RTCX_IDX_EXT, {4'h1, 2'b00, c[1:0]});
      // old source may still pulse once; align on a new rising pulse
      repeat (2) @(posedge i_mclk);
      do gap(2, n); while (mon[2] !== 1'b1);
      gap(2, n);
      gap(2, m);
      e = (c == 0) ? TF : (c == 1) ? TS : (c == 2) ? SC : 60 * SC;
      chk(n + m, e);
    end
    wr(`RTCX_IDX_EXT, 8'h00);
    // last pulse of the running timer may still be in flight
    @(posedge i_mclk);
    n = 0;
    repeat (150) begin
      @(posedge i_mclk);
      if (mon[2] !== 1'b0) n++;
    end
    chk(n, 0);
    // irq width after a second update, then after a minute update
    for (int u = 0; u < 2; u++) begin
      wr(`RTCX_IDX_EXT, {2'b00, u[0], 5'h00});
      wr(`RTCX_IDX_SEC, 8'h58);
      do gap(0, n); while (mon[0] !== 1'b1);
      gap(0, n);
      chk(n, u ? RM : RS);
    end
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      t = {4'(rng[4] ? 1 : 0), 4'(rng[15:8] % 10), 4'(rng[18:16] % 6),
           4'(rng[27:20] % 10), 4'(rng[31:29] % 6),
           4'(rng[7:0] % 10)};
      if (k < 3) t = corner[k];
      sync_sec();
      wr(`RTCX_IDX_HOUR, t[23:16] | 8'hc0);
      wr(`RTCX_IDX_MIN, t[15:8] | 8'h80);
      wr(`RTCX_IDX_SEC, t[7:0] | 8'h80);
      rc(`RTCX_IDX_SEC, t[7:0]);
      rc(`RTCX_IDX_HOUR, t[23:16]);
      sync_sec();
      t = nxt(t);
      chk(rd, {24'h00_0000, t[7:0]});
      rc(`RTCX_IDX_MIN, t[15:8]);
      rc(`RTCX_IDX_HOUR, t[23:16]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
